// [include/fkg_pkg.sv]
// Shared constants, types and helpers for the flash key and download guard
package fkg_pkg;

   // Register offsets on the byte-wide register port
   localparam logic [2:0]  OFS_KEY      = 3'h0;
   localparam logic [2:0]  OFS_DEST     = 3'h1;
   localparam logic [2:0]  OFS_CTRL     = 3'h2;
   localparam logic [2:0]  OFS_STAT     = 3'h3;
   localparam logic [2:0]  OFS_MASK     = 3'h4;

   // Field positions
   localparam int          DEST_ERR_BIT = 7;
   localparam int          CTRL_REQ_BIT = 0;
   localparam int          STAT_DONE    = 0;
   localparam int          STAT_DERR    = 1;
   localparam int          STAT_PROT    = 2;

   // Key values and reset values
   localparam logic [7:0]  KEY_COPY     = 8'hA5;
   localparam logic [7:0]  KEY_PROG     = 8'h5A;
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [2:0]  RST_EVT      = 3'h0;

   // Destination windows
   localparam logic [6:0]  SEL_MAX      = 7'h02;
   localparam logic [23:0] RAM_BASE     = 24'hFF_9000;
   localparam logic [12:0] COPY_LEN     = 13'h1000;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_COPY = 1'b1
   } fkg_state_e;

   function automatic logic selInRange(input logic [6:0] sel);
      selInRange = (sel <= SEL_MAX);
   endfunction : selInRange

   // Each selector step moves the window by one 4-kbyte page
   function automatic logic [23:0] destBase(input logic [6:0] sel);
      destBase = RAM_BASE + {5'h00, sel, 12'h000};
   endfunction : destBase

endpackage : fkg_pkg

// [hdl/fkg_copy_engine.sv]
// Byte copy engine that fills one 4-kbyte RAM window from the routine store
module fkg_copy_engine (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Control
   input  wire logic        start,
   input  wire logic [23:0] baseIn,
   output logic             busy,
   output logic             done,
   // Source store, combinational read
   output logic [11:0]      srcAddr,
   input  wire logic [7:0]  srcData,
   // RAM write side
   output logic [23:0]      ramAddr,
   output logic [7:0]       ramWdata,
   output logic             ramWe
);

   typedef struct packed {
      logic        busy;
      logic        iss;
      logic [12:0] cnt;
      logic [23:0] base;
      logic [11:0] src;
      logic [23:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        done;
   } fkg_eng_s;

   fkg_eng_s r_r;
   fkg_eng_s r_nxt;

   always_comb begin
      r_nxt       = r_r;
      r_nxt.done  = 1'b0;
      r_nxt.iss   = 1'b0;
      r_nxt.we    = r_r.iss;
      r_nxt.addr  = r_r.base + {12'h000, r_r.src};
      r_nxt.wdata = srcData;
      if (start && !r_r.busy) begin
         r_nxt.busy = 1'b1;
         r_nxt.cnt  = 13'h0000;
         r_nxt.base = baseIn;
      end else if (r_r.busy) begin
         if (r_r.cnt != fkg_pkg::COPY_LEN) begin
            r_nxt.src = r_r.cnt[11:0];
            r_nxt.iss = 1'b1;
            r_nxt.cnt = r_r.cnt + 13'h0001;
         end else if (!r_r.iss) begin
            // Finish only after the last byte has been written
            r_nxt.busy = 1'b0;
            r_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign busy     = r_r.busy;
   assign done     = r_r.done;
   assign srcAddr  = r_r.src;
   assign ramAddr  = r_r.addr;
   assign ramWdata = r_r.wdata;
   assign ramWe    = r_r.we;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_window_bound : assert property (ramWe |-> (ramAddr - r_r.base) < 24'h00_1000)
      else $error("RAM write outside the 4-kbyte window");
   a_done_count : assert property (done |-> r_r.cnt == fkg_pkg::COPY_LEN)
      else $error("Copy finished before the full window was written");

endmodule : fkg_copy_engine

// [hdl/fkg_guard.sv]
// Flash key protection and download destination guard with copy sequencer
//
// The placing of the registers and the strobed register port were decided locally.
module fkg_guard (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [2:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [7:0]       regRdata,
   // Interrupt
   output logic             irq,
   // Program and erase strobe from the running routine
   input  wire logic        progEraseReq,
   output logic             progEraseGo,
   output logic             progEraseEnable,
   // Routine source store
   output logic [11:0]      srcAddr,
   input  wire logic [7:0]  srcData,
   // On-chip RAM write side
   output logic [23:0]      ramAddr,
   output logic [7:0]       ramWdata,
   output logic             ramWe,
   output logic             copyBusy
);

   typedef struct packed {
      fkg_pkg::fkg_state_e state;
      logic [7:0]          key;
      logic                errFlag;
      logic [6:0]          sel;
      logic [23:0]         copyBase;
      logic                start;
      logic [2:0]          stat;
      logic [2:0]          mask;
      logic [7:0]          rdata;
      logic                irq;
      logic                peGo;
      logic                peEn;
      logic [12:0]         copyCyc;
   } fkg_regs_s;

   fkg_regs_s st_r;
   fkg_regs_s st_nxt;

   // Request edge to engine done: launch, one issue per byte, last write, finish
   localparam logic [12:0] COPY_CYCLES = fkg_pkg::COPY_LEN + 13'h0003;

   logic engDone;
   logic engBusy;
   logic wrKey;
   logic wrDest;
   logic wrCtrl;
   logic wrMask;
   logic rdStat;
   logic copyAsk;
   logic [2:0] events;

   always_comb begin
      wrKey   = regWr && (regAddr == fkg_pkg::OFS_KEY);
      wrDest  = regWr && (regAddr == fkg_pkg::OFS_DEST);
      wrCtrl  = regWr && (regAddr == fkg_pkg::OFS_CTRL);
      wrMask  = regWr && (regAddr == fkg_pkg::OFS_MASK);
      rdStat  = regRd && (regAddr == fkg_pkg::OFS_STAT);
      copyAsk = wrCtrl && regWdata[fkg_pkg::CTRL_REQ_BIT];
   end

   always_comb begin
      st_nxt       = st_r;
      st_nxt.start = 1'b0;
      events       = 3'h0;

      // Key holds until software rewrites it
      if (wrKey) begin
         st_nxt.key = regWdata;
      end
      if (wrDest) begin
         st_nxt.errFlag = regWdata[fkg_pkg::DEST_ERR_BIT];
         st_nxt.sel     = regWdata[6:0];
      end
      if (wrMask) begin
         st_nxt.mask = regWdata[2:0];
      end

      case (st_r.state)
         fkg_pkg::ST_IDLE: begin
            // Requests without the copy key fall through here unnoticed
            if (copyAsk && (st_r.key == fkg_pkg::KEY_COPY)) begin
               if (fkg_pkg::selInRange(st_r.sel)) begin
                  // Base is latched now so a later destination write cannot move it
                  st_nxt.copyBase = fkg_pkg::destBase(st_r.sel);
                  st_nxt.start    = 1'b1;
                  st_nxt.state    = fkg_pkg::ST_COPY;
               end else begin
                  st_nxt.errFlag = 1'b1;
                  events[fkg_pkg::STAT_DERR] = 1'b1;
               end
            end
         end
         fkg_pkg::ST_COPY: begin
            // Error flag is left alone on success
            if (engDone) begin
               st_nxt.state = fkg_pkg::ST_IDLE;
               events[fkg_pkg::STAT_DONE] = 1'b1;
            end
         end
         default: begin
            st_nxt.state = fkg_pkg::ST_IDLE;
         end
      endcase

      // Strobes from the routine only reach the array with the program key
      st_nxt.peGo = progEraseReq && (st_r.key == fkg_pkg::KEY_PROG);
      if (progEraseReq && (st_r.key != fkg_pkg::KEY_PROG)) begin
         events[fkg_pkg::STAT_PROT] = 1'b1;
      end
      st_nxt.peEn = (st_nxt.key == fkg_pkg::KEY_PROG);

      // Cycles spent in a copy, so a stuck engine shows up as an overrun
      if (st_r.state == fkg_pkg::ST_COPY) begin
         st_nxt.copyCyc = st_r.copyCyc + 13'h0001;
      end else begin
         st_nxt.copyCyc = 13'h0000;
      end

      // Read clears status; a same-cycle event still lands
      if (rdStat) begin
         st_nxt.stat = events;
      end else begin
         st_nxt.stat = st_r.stat | events;
      end
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

      st_nxt.rdata = fkg_pkg::RST_BYTE;
      if (regRd) begin
         case (regAddr)
            fkg_pkg::OFS_KEY: begin
               st_nxt.rdata = st_r.key;
            end
            fkg_pkg::OFS_DEST: begin
               st_nxt.rdata = {st_r.errFlag, st_r.sel};
            end
            fkg_pkg::OFS_CTRL: begin
               st_nxt.rdata = {7'h00, st_r.state == fkg_pkg::ST_COPY};
            end
            fkg_pkg::OFS_STAT: begin
               st_nxt.rdata = {5'h00, st_r.stat};
            end
            fkg_pkg::OFS_MASK: begin
               st_nxt.rdata = {5'h00, st_r.mask};
            end
            default: begin
               st_nxt.rdata = fkg_pkg::RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   fkg_copy_engine u_engine (
      .clk      (clk),
      .rst      (rst),
      .start    (st_r.start),
      .baseIn   (st_r.copyBase),
      .busy     (engBusy),
      .done     (engDone),
      .srcAddr  (srcAddr),
      .srcData  (srcData),
      .ramAddr  (ramAddr),
      .ramWdata (ramWdata),
      .ramWe    (ramWe)
   );

   assign regRdata        = st_r.rdata;
   assign irq             = st_r.irq;
   assign progEraseGo     = st_r.peGo;
   assign progEraseEnable = st_r.peEn;
   assign copyBusy        = (st_r.state == fkg_pkg::ST_COPY);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Copy sequencing
   a_copy_key_ok : assert property (
      copyAsk && st_r.state == fkg_pkg::ST_IDLE && st_r.key == fkg_pkg::KEY_COPY
      && st_r.sel <= fkg_pkg::SEL_MAX
      |=> st_r.start && copyBusy ##3 ramWe && ramAddr == st_r.copyBase)
      else $error("Keyed in-range request did not start a copy at the window base");

   a_copy_key_bad : assert property (
      copyAsk && st_r.state == fkg_pkg::ST_IDLE && st_r.key != fkg_pkg::KEY_COPY
      |=> !st_r.start && !copyBusy ##1 !ramWe)
      else $error("Copy started without the copy key");

   a_dest_range_err : assert property (
      copyAsk && st_r.state == fkg_pkg::ST_IDLE && st_r.key == fkg_pkg::KEY_COPY
      && st_r.sel > fkg_pkg::SEL_MAX
      |=> st_r.errFlag && !copyBusy && st_r.stat[fkg_pkg::STAT_DERR])
      else $error("Out-of-range selector did not flag and stop the copy");

   a_err_readback : assert property (
      regRd && regAddr == fkg_pkg::OFS_DEST
      |=> regRdata == {$past(st_r.errFlag), $past(st_r.sel)})
      else $error("Destination readback does not match flag and selector");

   // Program gating, key and copy invariants
   a_pe_allowed : assert property (
      progEraseReq && st_r.key == fkg_pkg::KEY_PROG |=> progEraseGo)
      else $error("Program strobe dropped with program key set");

   a_pe_blocked : assert property (
      progEraseReq && st_r.key != fkg_pkg::KEY_PROG
      |=> !progEraseGo && st_r.stat[fkg_pkg::STAT_PROT])
      else $error("Program strobe passed without program key");

   a_key_holds : assert property (
      !wrKey |=> st_r.key == $past(st_r.key))
      else $error("Key changed without a key write");

   a_err_kept : assert property (
      copyBusy && !wrDest |=> st_r.errFlag == $past(st_r.errFlag))
      else $error("Error flag changed during a copy");

   a_req_clears : assert property (
      engDone |=> !copyBusy && st_r.stat[fkg_pkg::STAT_DONE])
      else $error("Request bit did not clear at copy end");

   a_base_select : assert property (
      st_r.start |-> (st_r.sel == 7'h00 && st_r.copyBase == 24'hFF_9000)
      || (st_r.sel == 7'h01 && st_r.copyBase == 24'hFF_A000)
      || (st_r.sel == 7'h02 && st_r.copyBase == 24'hFF_B000))
      else $error("Copy base does not follow the selector");

   a_irq_level : assert property (
      $rose(st_r.stat[fkg_pkg::STAT_DONE]) && st_r.mask[fkg_pkg::STAT_DONE] |-> irq)
      else $error("Unmasked done event did not raise the interrupt");

   a_copy_length : assert property (
      engDone |-> st_r.copyCyc == COPY_CYCLES)
      else $error("Copy did not take the full window length");

   a_copy_bound : assert property (
      copyBusy |-> st_r.copyCyc <= COPY_CYCLES)
      else $error("Copy ran past its expected length");

   a_last_byte : assert property (
      engDone |-> $past(ramWe) && $past(ramAddr) == st_r.copyBase + 24'h00_0FFF)
      else $error("Last byte did not land at the top of the window");

   a_busy_refuse : assert property (
      copyAsk && copyBusy |=> !st_r.start)
      else $error("Copy request accepted while a copy runs");

   a_no_ram_idle : assert property (
      !copyBusy |-> !ramWe)
      else $error("RAM written outside a copy");

   a_engine_inside : assert property (
      engBusy |-> copyBusy)
      else $error("Engine busy while the request bit reads 0");

   a_err_set_only : assert property (
      !wrDest && !copyAsk |=> st_r.errFlag == $past(st_r.errFlag))
      else $error("Error flag changed without a write or a refused copy");

   a_err_in_range : assert property (
      copyAsk && st_r.state == fkg_pkg::ST_IDLE && st_r.key == fkg_pkg::KEY_COPY
      && st_r.sel <= fkg_pkg::SEL_MAX
      |=> st_r.errFlag == $past(st_r.errFlag))
      else $error("In-range request changed the error flag");

   a_pe_key : assert property (
      progEraseGo |-> $past(st_r.key) == fkg_pkg::KEY_PROG)
      else $error("Program strobe passed on without the program key");

   a_pe_single : assert property (
      !progEraseReq |=> !progEraseGo)
      else $error("Program strobe without a request");

   a_pe_enable : assert property (
      progEraseEnable == (st_r.key == fkg_pkg::KEY_PROG))
      else $error("Program enable level does not follow the key");

   // Register port and status
   a_rdata_idle : assert property (
      !regRd |=> regRdata == 8'h00)
      else $error("Read data not zero outside a read");

   a_ctrl_readback : assert property (
      regRd && regAddr == fkg_pkg::OFS_CTRL |=> regRdata == {7'h00, $past(copyBusy)})
      else $error("Request bit readback does not follow the copy");

   a_unmapped_read : assert property (
      regRd && regAddr > fkg_pkg::OFS_MASK |=> regRdata == 8'h00)
      else $error("Unmapped offset read nonzero");

   a_irq_release : assert property (
      $fell(irq) |-> $past(rdStat) || $past(wrMask))
      else $error("Interrupt dropped without a status read or mask write");

   a_stat_sticky : assert property (
      !rdStat |=> (st_r.stat & $past(st_r.stat)) == $past(st_r.stat))
      else $error("Status bit cleared without a status read");

   a_stat_read_clear : assert property (
      rdStat && !progEraseReq && !engDone |=> st_r.stat == 3'h0)
      else $error("Status read did not clear the status");

   a_key_load : assert property (
      wrKey |=> st_r.key == $past(regWdata))
      else $error("Key write did not load the whole byte");

   a_dest_load : assert property (
      wrDest |=> {st_r.errFlag, st_r.sel} == $past(regWdata))
      else $error("Destination write did not load flag and selector");

   c_copy_done : cover property (engDone);
   c_dest_error : cover property ($rose(st_r.errFlag) && !$past(wrDest));
   c_pe_go : cover property (progEraseGo);
   c_pe_refused : cover property (progEraseReq && st_r.key != fkg_pkg::KEY_PROG);
   c_busy_request : cover property (copyAsk && copyBusy);

endmodule : fkg_guard

// [verification/tb_fkg_guard.sv]
// Self-checking bench for the flash key and download guard
module tb_fkg_guard;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk;
   logic        rst;
   logic [2:0]  regAddr;
   logic [7:0]  regWdata;
   logic        regWr;
   logic        regRd;
   logic [7:0]  regRdata;
   logic        irq;
   logic        progEraseReq;
   logic        progEraseGo;
   logic        progEraseEnable;
   logic [11:0] srcAddr;
   logic [7:0]  srcData;
   logic [23:0] ramAddr;
   logic [7:0]  ramWdata;
   logic        ramWe;
   logic        copyBusy;
   int          miscompares;
   int          cmp_count;
   int          cycles;
   int          mKey;
   int          mDest;
   int          mStat;
   int          mMask;
   logic [7:0]  rnd;
   logic [7:0]  keys [4];
   logic [23:0] bases [3];

   fkg_guard fkg_guard_i (
      .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .irq(irq), .progEraseReq(progEraseReq),
      .progEraseGo(progEraseGo), .progEraseEnable(progEraseEnable), .srcAddr(srcAddr),
      .srcData(srcData), .ramAddr(ramAddr), .ramWdata(ramWdata), .ramWe(ramWe),
      .copyBusy(copyBusy)
   );

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // Routine store pattern: every byte of the 4-kbyte window differs from its neighbours, except 0x7FF and 0x800, which both hold 0x88
   function automatic logic [7:0] store(input logic [11:0] k);
      store = k[7:0] ^ {k[11:8], k[11:8]};
   endfunction : store

   assign srcData = store(srcAddr);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      case (a)
         fkg_pkg::OFS_KEY:  mKey = d;
         fkg_pkg::OFS_DEST: mDest = d;
         fkg_pkg::OFS_MASK: mMask = d & 8'h07;
         default: ;
      endcase
   endtask : wr

   task automatic rd(input logic [2:0] a);
      int e;
      case (a)
         fkg_pkg::OFS_KEY:  e = mKey;
         fkg_pkg::OFS_DEST: e = mDest;
         fkg_pkg::OFS_STAT: e = mStat;
         fkg_pkg::OFS_MASK: e = mMask;
         default:           e = 0;
      endcase
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      chk(24'(regRdata), 24'(e));
      if (a == fkg_pkg::OFS_STAT) mStat = 0;
   endtask : rd

   task automatic chk_irq;
      @(negedge clk);
      chk(24'(irq), 24'((mStat & mMask) != 0));
   endtask : chk_irq

   // Watches the whole copy; the loop bound also cuts short an engine that never ends
   task automatic copy_watch(input logic [23:0] base);
      int n;
      n = 0;
      for (int c = 0; c < 4200 && (c < 3 || copyBusy === 1'b1); c++) begin
         @(negedge clk);
         if (ramWe === 1'b1) begin
            chk(ramAddr, 24'(base + n));
            chk(24'(ramWdata), 24'(store(n[11:0])));
            n++;
         end
      end
      chk(24'(n), 24'd4096);
      chk(24'(copyBusy), 24'h0);
   endtask : copy_watch

   task automatic pulse_prog(input logic expGo);
      @(posedge clk);
      progEraseReq <= 1'b1;
      @(posedge clk);
      progEraseReq <= 1'b0;
      @(negedge clk);
      chk(24'(progEraseGo), 24'(expGo));
      chk(24'(progEraseEnable), 24'(expGo));
      if (!expGo) mStat = mStat | 4;
   endtask : pulse_prog

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      {regAddr, regWdata, regWr, regRd, progEraseReq} = '0;
      rst = 1'b1;
      {miscompares, cmp_count, mKey, mDest, mStat, mMask} = '0;
      rnd = 8'd47;
      bases = '{24'hFF_9000, 24'hFF_A000, 24'hFF_B000};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd(a[2:0]);
      foreach (keys[i]) begin
         rnd = lfsr(rnd);
         wr(3'(i < 2 ? i : i + 2), rnd);
         rd(3'(i < 2 ? i : i + 2));
      end
      // Keys that must not open the copy: near miss, swapped, random
      rnd = lfsr(rnd);
      keys = '{fkg_pkg::KEY_PROG, 8'hA4, 8'h25, rnd & 8'h7F};
      foreach (keys[i]) begin
         wr(fkg_pkg::OFS_KEY, keys[i]);
         wr(fkg_pkg::OFS_DEST, 8'h01);
         wr(fkg_pkg::OFS_CTRL, 8'h01);
         repeat (3) @(negedge clk);
         chk(24'({copyBusy, ramWe}), 24'h0);
         rd(fkg_pkg::OFS_CTRL);
      end
      // Out-of-range selectors: boundary and random
      wr(fkg_pkg::OFS_MASK, 8'h07);
      wr(fkg_pkg::OFS_KEY, fkg_pkg::KEY_COPY);
      for (int j = 0; j < 2; j++) begin
         rnd = lfsr(rnd);
         wr(fkg_pkg::OFS_DEST, j == 0 ? 8'h03 : 8'h03 + rnd % 8'd125);
         wr(fkg_pkg::OFS_CTRL, 8'h01);
         mDest = mDest | 8'h80;
         mStat = mStat | 2;
         repeat (3) @(negedge clk);
         chk(24'({copyBusy, ramWe}), 24'h0);
         chk_irq();
         rd(fkg_pkg::OFS_DEST);
         rd(fkg_pkg::OFS_STAT);
         chk_irq();
      end
      // Each legal window; the middle one with the interrupt masked
      for (int s = 0; s < 3; s++) begin
         wr(fkg_pkg::OFS_MASK, s == 1 ? 8'h00 : 8'h07);
         wr(fkg_pkg::OFS_DEST, 8'(s));
         wr(fkg_pkg::OFS_CTRL, 8'h01);
         // A second request or a moved destination during the copy must not disturb it
         if (s != 0) wr(s == 1 ? fkg_pkg::OFS_CTRL : fkg_pkg::OFS_DEST, 8'h01);
         copy_watch(bases[s]);
         mStat = mStat | 1;
         chk_irq();
         rd(fkg_pkg::OFS_CTRL);
         rd(fkg_pkg::OFS_DEST);
         rd(fkg_pkg::OFS_STAT);
      end
      // Program strobe gating under each kind of key
      wr(fkg_pkg::OFS_MASK, 8'h04);
      keys = '{fkg_pkg::KEY_PROG, fkg_pkg::KEY_COPY, 8'h5B, 8'h00};
      foreach (keys[i]) begin
         wr(fkg_pkg::OFS_KEY, keys[i]);
         pulse_prog(keys[i] == fkg_pkg::KEY_PROG);
         chk_irq();
         rd(fkg_pkg::OFS_STAT);
      end
      finish_test();
   end

endmodule : tb_fkg_guard
